// *** sld_driver.sv ***
// Behaviour
// RULE1 - Shift and latch act on rising edges of their own clock inputs.
// RULE2 - Every bit has a shift stage and an independently clocked latch stage.
// RULE3 - Only the serial data input loads the first shift stage.
// RULE4 - Each shift pulse moves data one stage; first stage takes the input.
// RULE5 - First stage captures the inverse of the serial data input.
// RULE6 - Latch pulse copies the whole shift register to latches and outputs.
// RULE7 - Parallel outputs are open drain: sink or released, never driven high.
// RULE8 - Cascade output always shows the last shift stage; the code holds it low while direct reset is low.
// RULE9 - Direct reset low forces outputs to reset and sets all stages.
// RULE10 - Direct reset acts without any shift or latch clock edge.
// RULE11 - Output enable high releases parallel outputs; cascade stays driven.
// RULE12 - Output enable never disturbs shift contents or shifting.
// RULE13 - Register length is a parameter of 8, 16, 24 or 32.
// RULE14 - Enabled output sinks when its latch holds low, released when high.
`timescale 1ns/1ns
`include "sld_defs.svh"
module sld_driver #(
  parameter int WIDTH      = `SLD_DEFAULT_WIDTH,
  parameter int FIFO_DEPTH = `SLD_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                      CLK_SYS,
  input  wire logic                      RST_B,
  input  wire logic                      CE,
  // Host pins
  input  wire logic                      SER_DATA_IN,
  input  wire logic                      SHIFT_CLOCK_IN,
  input  wire logic                      LATCH_CLOCK_IN,
  input  wire logic                      DIRECT_RESET_B,
  input  wire logic                      OUT_ENABLE_B,
  // Open-drain sink pins
  output logic [WIDTH-1:0]               PARALLEL_SINK_OUTPUTS_O,
  output logic [WIDTH-1:0]               PARALLEL_SINK_OUTPUTS_OE,
  // Cascade
  output logic                           SERIAL_CASCADE_OUT,
  // Status
  output logic                           IN_READY,
  output logic                           OVERRUN,
  output logic                           BUSY,
  output logic [WIDTH-1:0]               LATCHED_VIEW,
  output logic [$clog2(FIFO_DEPTH):0]    PENDING
);

  import sld_pkg::*;

  localparam int NP = `SLD_PIN_COUNT;
  // Clamp keeps a zero settle time from wrapping the counter
  localparam int SETTLE_CYC_I = (`SLD_LATCH_SETTLE_CYC < 1) ? 1 : `SLD_LATCH_SETTLE_CYC;
  localparam logic [3:0] SETTLE_CYC = 4'(SETTLE_CYC_I);
  localparam int CW = $clog2(WIDTH) + 1;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sync1_r;
  logic [NP-1:0] sync2_r;
  logic [NP-1:0] sync3_r;
  logic [NP-1:0] lvl_r;
  logic [NP-1:0] lvl_d_r;

  assign pin_raw[`SLD_PIN_DATA]      = SER_DATA_IN;
  assign pin_raw[`SLD_PIN_SHIFT_CLK] = SHIFT_CLOCK_IN;
  assign pin_raw[`SLD_PIN_LATCH_CLK] = LATCH_CLOCK_IN;
  assign pin_raw[`SLD_PIN_DRST_B]    = DIRECT_RESET_B;
  assign pin_raw[`SLD_PIN_OE_B]      = OUT_ENABLE_B;

  localparam logic [NP-1:0] PIN_RST = `SLD_PIN_RESET;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      // Reset to idle pin levels so no false edge follows reset
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          sync1_r[gp] <= PIN_RST[gp];
          sync2_r[gp] <= PIN_RST[gp];
          sync3_r[gp] <= PIN_RST[gp];
        end else if (CE) begin
          sync1_r[gp] <= pin_raw[gp];
          sync2_r[gp] <= sync1_r[gp];
          sync3_r[gp] <= sync2_r[gp];
        end
      end

      // Level moves only once two stages agree: rejects one-cycle glitches
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          lvl_r[gp]   <= PIN_RST[gp];
          lvl_d_r[gp] <= PIN_RST[gp];
        end else if (CE) begin
          if (sync2_r[gp] == sync3_r[gp]) begin
            lvl_r[gp] <= sync3_r[gp];
          end
          lvl_d_r[gp] <= lvl_r[gp];
        end
      end
    end
  endgenerate

  // ****************************************
  // Event decode
  // ****************************************
  logic data_lvl;
  logic cks_rise;
  logic ckl_rise;
  logic drst_lvl;
  logic oe_dis_lvl;
  logic drst_now;

  assign data_lvl   = lvl_r[`SLD_PIN_DATA];
  // RULE1 rising edges only
  assign cks_rise   = lvl_r[`SLD_PIN_SHIFT_CLK] & ~lvl_d_r[`SLD_PIN_SHIFT_CLK];
  assign ckl_rise   = lvl_r[`SLD_PIN_LATCH_CLK] & ~lvl_d_r[`SLD_PIN_LATCH_CLK];
  assign drst_lvl   = ~lvl_r[`SLD_PIN_DRST_B];
  assign oe_dis_lvl = lvl_r[`SLD_PIN_OE_B];

  // RULE10 raw pin forces outputs at once
  // Raw pin so the pins react before the synchroniser catches up
  assign drst_now   = ~DIRECT_RESET_B | drst_lvl;

  // ****************************************
  // Command queue
  // ****************************************
  sld_cmd_s                      push_cmd;
  logic                          push_valid;
  logic                          fifo_in_ready;
  sld_cmd_s                      pop_cmd;
  logic                          pop_valid;
  logic                          pop_ready;
  logic                          pop;
  logic                          latch_pend_r;
  logic                          overrun_r;
  logic                          drop;
  logic [$clog2(FIFO_DEPTH):0]   fifo_level;

  // A latch in the same cycle as a shift waits one cycle so it sees the shift.
  // Two shift edges cannot fall in consecutive cycles after filtering.
  always_comb begin
    push_cmd   = '{kind: SLD_CMD_SHIFT, bit_val: data_lvl};
    push_valid = 1'b0;
    if (latch_pend_r) begin
      push_cmd   = '{kind: SLD_CMD_LATCH, bit_val: 1'b0};
      push_valid = 1'b1;
    end else if (cks_rise) begin
      // RULE3 only the data pin feeds the chain
      push_cmd   = '{kind: SLD_CMD_SHIFT, bit_val: data_lvl};
      push_valid = 1'b1;
    end else if (ckl_rise) begin
      push_cmd   = '{kind: SLD_CMD_LATCH, bit_val: 1'b0};
      push_valid = 1'b1;
    end
  end

  // Only shift edges are ever lost; a refused latch waits in the pending flag
  assign drop = CE & ~drst_lvl & cks_rise &
                (latch_pend_r | ~fifo_in_ready);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      latch_pend_r <= 1'b0;
    end else if (CE) begin
      if (drst_lvl) begin
        latch_pend_r <= 1'b0;
      end else if (latch_pend_r) begin
        // Pending latch retries until the queue takes it
        latch_pend_r <= ~fifo_in_ready;
      end else if (ckl_rise && (cks_rise || !fifo_in_ready)) begin
        // Behind a same-cycle shift, or refused by a full queue
        latch_pend_r <= 1'b1;
      end
    end
  end

  // Lost events are sticky; direct reset clears them and no loss is counted under it
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      overrun_r <= 1'b0;
    end else if (CE) begin
      if (drop) begin
        overrun_r <= 1'b1;
      end else if (drst_lvl) begin
        overrun_r <= 1'b0;
      end
    end
  end

  sld_fifo #(
    .WIDTH ($bits(sld_cmd_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .en        (CE),
    .flush     (drst_lvl),
    .in_valid  (push_valid & ~drst_lvl),
    .in_ready  (fifo_in_ready),
    .in_data   (push_cmd),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_cmd),
    .level     (fifo_level)
  );

  // ****************************************
  // Engine
  // ****************************************
  sld_state_e  state_r;
  logic [3:0]  settle_r;
  logic        do_shift;
  logic        do_latch;

  assign pop_ready = (state_r == SLD_RUN) & ~drst_lvl;
  assign pop       = CE & pop_valid & pop_ready;
  assign do_shift  = pop & (pop_cmd.kind == SLD_CMD_SHIFT);
  assign do_latch  = pop & (pop_cmd.kind == SLD_CMD_LATCH);

  // Settle time after each latch stalls the drain, so the queue can fill
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state_r  <= SLD_RUN;
      settle_r <= '0;
    end else if (CE) begin
      if (drst_lvl) begin
        state_r  <= SLD_RUN;
        settle_r <= '0;
      end else begin
        unique case (state_r)
          SLD_RUN: begin
            if (do_latch) begin
              state_r  <= SLD_SETTLE;
              settle_r <= SETTLE_CYC - 4'h1;
            end
          end
          SLD_SETTLE: begin
            if (settle_r == 4'h0) begin
              state_r <= SLD_RUN;
            end else begin
              settle_r <= settle_r - 4'h1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Shift and latch stages
  // ****************************************
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] shift_in;

  // RULE5 first stage takes inverted data
  assign shift_in = {shift_r[WIDTH-2:0], ~pop_cmd.bit_val};

  // RULE13 length set by WIDTH
  // RULE2 two flops per bit
  genvar gb;
  generate
    for (gb = 0; gb < WIDTH; gb++) begin : g_bit
      // RULE12 enable pin absent from this path
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          shift_r[gb] <= `SLD_STAGE_RESET;
        end else if (CE) begin
          // RULE9 direct reset sets stages
          if (drst_lvl) begin
            shift_r[gb] <= `SLD_STAGE_RESET;
          // RULE4 one stage per pulse
          end else if (do_shift) begin
            shift_r[gb] <= shift_in[gb];
          end
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          latch_r[gb] <= `SLD_STAGE_RESET;
        end else if (CE) begin
          if (drst_lvl) begin
            latch_r[gb] <= `SLD_STAGE_RESET;
          // RULE6 copy whole register
          end else if (do_latch) begin
            latch_r[gb] <= shift_r[gb];
          end
        end
      end

      // Combinational so direct reset releases the pins at once
      // RULE14 sink on latched low
      // RULE11 released while disabled
      assign PARALLEL_SINK_OUTPUTS_OE[gb] = ~latch_r[gb] & ~oe_dis_lvl & ~drst_now;
    end
  endgenerate

  // ****************************************
  // Pin drive
  // ****************************************
  // RULE7 open drain, low only
  assign PARALLEL_SINK_OUTPUTS_O = '0;

  // Reads low during direct reset even though the stages are set
  // RULE8 last stage to cascade
  assign SERIAL_CASCADE_OUT = shift_r[WIDTH-1] & ~drst_now;

  // ****************************************
  // Status
  // ****************************************
  logic [CW-1:0]               shifted_r;
  logic [$clog2(FIFO_DEPTH):0] pending_r;

  // Bits shifted since last latch, saturating at the length
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      shifted_r <= '0;
    end else if (CE) begin
      if (drst_lvl || do_latch) begin
        shifted_r <= '0;
      end else if (do_shift && shifted_r != CW'(WIDTH)) begin
        shifted_r <= shifted_r + 1'b1;
      end
    end
  end

  // Registered so the level pins do not ripple from the pointer subtractor
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      pending_r <= '0;
    end else if (CE) begin
      pending_r <= fifo_level;
    end
  end

  assign IN_READY     = fifo_in_ready & ~latch_pend_r & ~drst_lvl;
  assign OVERRUN      = overrun_r;
  assign BUSY         = pop_valid | latch_pend_r | (state_r != SLD_RUN) | (shifted_r != '0);
  assign LATCHED_VIEW = latch_r;
  assign PENDING      = pending_r;

endmodule

// *** sld_defs.svh ***
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

// ****************************************
// Geometry
// ****************************************
`define SLD_DEFAULT_WIDTH      8
`define SLD_FIFO_DEPTH         16

// ****************************************
// Pin vector positions
// ****************************************
`define SLD_PIN_DATA           0
`define SLD_PIN_SHIFT_CLK      1
`define SLD_PIN_LATCH_CLK      2
`define SLD_PIN_DRST_B         3
`define SLD_PIN_OE_B           4
`define SLD_PIN_COUNT          5

// ****************************************
// Reset values
// ****************************************
// Clocks low, direct reset idle, outputs disabled
`define SLD_PIN_RESET          5'h18
`define SLD_STAGE_RESET        1'b1

// ****************************************
// Timing
// ****************************************
`define SLD_CLK_PERIOD_NS      50
`define SLD_LATCH_SETTLE_NS    100
`define SLD_LATCH_SETTLE_CYC \
  ((`SLD_LATCH_SETTLE_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)

`endif

// *** sld_pkg.sv ***
package sld_pkg;

  // ****************************************
  // Command carried through the FIFO
  // ****************************************
  typedef enum logic {
    SLD_CMD_SHIFT,
    SLD_CMD_LATCH
  } sld_kind_e;

  typedef struct packed {
    sld_kind_e kind;
    logic      bit_val;
  } sld_cmd_s;

  // ****************************************
  // Engine states
  // ****************************************
  typedef enum logic {
    SLD_RUN,
    SLD_SETTLE
  } sld_state_e;

endpackage

// *** sld_fifo.sv ***
`timescale 1ns/1ns
module sld_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     en,
  input  wire logic                     flush,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // Fill level
  output logic [$clog2(DEPTH):0]        level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  assign level     = wr_ptr_r - rd_ptr_r;
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];
  assign push      = en & in_valid & in_ready & ~flush;
  assign pop       = en & out_valid & out_ready & ~flush;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
    end else if (en && flush) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_ptr_r <= '0;
    end else if (en && flush) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule

// *** sld_driver_assertions.sv ***
`timescale 1ns/1ns
module sld_driver_assertions #(
  parameter int WIDTH      = 8,
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic                      CLK_SYS,
  input wire logic                      RST_B,
  input wire logic                      CE,
  // Host pins
  input wire logic                      SHIFT_CLOCK_IN,
  input wire logic                      LATCH_CLOCK_IN,
  input wire logic                      DIRECT_RESET_B,
  input wire logic                      OUT_ENABLE_B,
  // Outputs
  input wire logic [WIDTH-1:0]          PARALLEL_SINK_OUTPUTS_O,
  input wire logic [WIDTH-1:0]          PARALLEL_SINK_OUTPUTS_OE,
  input wire logic                      SERIAL_CASCADE_OUT,
  input wire logic                      OVERRUN,
  input wire logic                      BUSY,
  input wire logic [WIDTH-1:0]          LATCHED_VIEW,
  input wire logic [$clog2(FIFO_DEPTH):0] PENDING
);
  // Cycles since shift clock, latch clock or direct reset activity; pin edges act only after the sync delay
  logic [3:0] quiet_r;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B || !CE || !DIRECT_RESET_B || SHIFT_CLOCK_IN || LATCH_CLOCK_IN) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  a_drain_zero: assert property (PARALLEL_SINK_OUTPUTS_O == '0)
    else $error("sink pin data not zero");
  a_direct_force: assert property (!DIRECT_RESET_B |->
    PARALLEL_SINK_OUTPUTS_OE == '0 && !SERIAL_CASCADE_OUT) else $error("direct reset not forcing");
  a_direct_set: assert property ((!DIRECT_RESET_B)[*7] |->
    LATCHED_VIEW == '1 && !OVERRUN && PENDING == '0) else $error("direct reset state wrong");
  a_disable_hold: assert property (OUT_ENABLE_B[*6] |-> PARALLEL_SINK_OUTPUTS_OE == '0)
    else $error("sink active while disabled");
  a_disable_bound: assert property ($rose(OUT_ENABLE_B) |-> ##[0:5]
    PARALLEL_SINK_OUTPUTS_OE == '0) else $error("disable too slow");
  a_sink_map: assert property ((!OUT_ENABLE_B && DIRECT_RESET_B)[*6] |->
    PARALLEL_SINK_OUTPUTS_OE == ~LATCHED_VIEW) else $error("sink not from latch");
  a_view_quiet: assert property (quiet_r >= 4'h8 |-> $stable(LATCHED_VIEW))
    else $error("latch moved without edge");
  a_cascade_quiet: assert property (quiet_r >= 4'h8 |-> $stable(SERIAL_CASCADE_OUT))
    else $error("cascade moved without edge");
  c_latch: cover property ($fell(BUSY));
  c_direct: cover property ($fell(DIRECT_RESET_B));
  c_disabled: cover property (OUT_ENABLE_B && LATCHED_VIEW != '1);
endmodule
bind sld_driver sld_driver_assertions #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .SHIFT_CLOCK_IN(SHIFT_CLOCK_IN),
  .LATCH_CLOCK_IN(LATCH_CLOCK_IN), .DIRECT_RESET_B(DIRECT_RESET_B),
  .OUT_ENABLE_B(OUT_ENABLE_B), .PARALLEL_SINK_OUTPUTS_O(PARALLEL_SINK_OUTPUTS_O),
  .PARALLEL_SINK_OUTPUTS_OE(PARALLEL_SINK_OUTPUTS_OE), .SERIAL_CASCADE_OUT(SERIAL_CASCADE_OUT),
  .OVERRUN(OVERRUN), .BUSY(BUSY), .LATCHED_VIEW(LATCHED_VIEW), .PENDING(PENDING));

// *** sld_host.sv ***
`timescale 1ns/1ns
module sld_host (
  // Clock
  input  wire logic clk,
  // Host pins
  output logic      ser_data,
  output logic      shift_clk,
  output logic      latch_clk
);
  initial begin
    ser_data = 1'b0;
    shift_clk = 1'b0;
    latch_clk = 1'b0;
  end
  // Each level held h cycles so the pin filter sees it cleanly
  task automatic pulse(input logic s, input logic l, input logic d, input int h);
    @(negedge clk);
    ser_data <= d;
    repeat (h) @(negedge clk);
    shift_clk <= s;
    latch_clk <= l;
    repeat (h) @(negedge clk);
    shift_clk <= 1'b0;
    latch_clk <= 1'b0;
    // Data no longer valid: show the inverse
    ser_data <= ~d;
    repeat (h) @(negedge clk);
  endtask
endmodule

// *** serial_in_latched_led_sink_driver_test.sv ***
`timescale 1ns/1ns
module serial_in_latched_led_sink_driver_test;
  import sld_pkg::*;
  localparam int W = 8;
  typedef struct packed {logic [W-1:0] oe; logic [W-1:0] view; logic casc;} sld_exp_s;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic drst_b = 1'b1;
  logic oe_b = 1'b1;
  logic ce = 1'b1;
  logic ser, sclk, lclk, casc, rdy, ovr, busy;
  logic busy_q = 1'b0;
  logic [W-1:0] q_o, q_oe, view, d;
  logic [W-1:0] sr = '1;
  logic [4:0] pend;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'hb3c5;
  int k;
  sld_exp_s expq[$];
  sld_exp_s e;
  always #25 clk_sys = ~clk_sys;
  sld_host i_sld_host (.clk(clk_sys), .ser_data(ser), .shift_clk(sclk), .latch_clk(lclk));
  sld_driver #(.WIDTH(W)) i_sld_driver (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce),
    .SER_DATA_IN(ser), .SHIFT_CLOCK_IN(sclk), .LATCH_CLOCK_IN(lclk), .DIRECT_RESET_B(drst_b),
    .OUT_ENABLE_B(oe_b), .PARALLEL_SINK_OUTPUTS_O(q_o), .PARALLEL_SINK_OUTPUTS_OE(q_oe),
    .SERIAL_CASCADE_OUT(casc), .IN_READY(rdy), .OVERRUN(ovr), .BUSY(busy),
    .LATCHED_VIEW(view), .PENDING(pend));
  // ****
  // Checking
  // ****
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A result is ready each time the block goes idle
  always @(negedge clk_sys) begin
    busy_q <= busy;
    if (busy_q === 1'b1 && busy === 1'b0) begin
      if (expq.size() == 0) check(8'h1, 8'h0, "stray result");
      else begin
        e = expq.pop_front();
        check(q_oe, e.oe, "sink");
        check(view, e.view, "latch");
        check({7'h0, casc}, {7'h0, e.casc}, "cascade");
      end
    end
  end
  // ****
  // Stimulus
  // ****
  // inverted shift
  task automatic shift(input logic dv, input int h);
    sr = {sr[W-2:0], ~dv};
    i_sld_host.pulse(1'b1, 1'b0, dv, h);
  endtask
  // Optional shift in the same cycle lands before the latch
  task automatic latch(input logic s, input logic dv, input int h);
    if (s) sr = {sr[W-2:0], ~dv};
    expq.push_back('{oe_b ? {W{1'b0}} : ~sr, sr, sr[W-1]});
    i_sld_host.pulse(s, 1'b1, dv, h);
  endtask
  task automatic idle;
    repeat (300) if (expq.size() != 0) @(negedge clk_sys);
    check(8'(expq.size()), 8'h00, "result late");
    repeat (8) @(negedge clk_sys);
  endtask
  initial begin
    #400000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check(view, 8'hff, "view reset");
    check(q_oe | q_o, 8'h00, "sink reset");
    check({4'h0, rdy, ovr, busy, casc}, 8'h09, "status reset");
    check({3'h0, pend}, 8'h00, "pending reset");
    oe_b <= 1'b0;
    repeat (8) @(negedge clk_sys);
    for (int f = 0; f < 4; f++) begin
      d = W'($random(seed));
      for (int i = 0; i < W; i++) shift(d[i], 2 + f % 2);
      latch(1'b0, 1'b0, 2);
      idle;
    end
    $display("frames done");
    oe_b <= 1'b1;
    repeat (8) @(negedge clk_sys);
    d = W'($random(seed));
    for (int i = 0; i < W; i++) begin
      if (i == 4) oe_b <= 1'b0;
      shift(d[i], 2);
    end
    latch(1'b1, d[0], 3);
    idle;
    oe_b <= 1'b1;
    repeat (8) @(negedge clk_sys);
    check(q_oe, 8'h00, "disabled");
    check({7'h0, casc}, {7'h0, sr[W-1]}, "cascade kept");
    oe_b <= 1'b0;
    repeat (8) @(negedge clk_sys);
    check(q_oe, ~sr, "enabled again");
    $display("enable done");
    for (int i = 0; i < 3; i++) shift(i[0], 2);
    expq.push_back('{{W{1'b0}}, {W{1'b1}}, 1'b0});
    drst_b <= 1'b0;
    @(negedge clk_sys);
    check(q_oe, 8'h00, "direct sink");
    check({7'h0, casc}, 8'h00, "direct cascade");
    repeat (12) @(negedge clk_sys);
    drst_b <= 1'b1;
    sr = '1;
    idle;
    check({7'h0, casc}, 8'h01, "stages set");
    $display("direct reset done");
    // One queued entry stands while a lone shift edge passes
    k = 0;
    fork
      shift(1'b1, 2);
      repeat (12) begin
        @(negedge clk_sys);
        if (pend > k) k = pend;
      end
    join
    check(8'(k), 8'h01, "queue peak");
    // Pin pulses while the enable is low are never seen
    ce <= 1'b0;
    i_sld_host.pulse(1'b1, 1'b1, 1'b0, 2);
    ce <= 1'b1;
    repeat (8) @(negedge clk_sys);
    check(view, 8'hff, "frozen latch");
    check({7'h0, casc}, {7'h0, sr[W-1]}, "frozen cascade");
    latch(1'b0, 1'b0, 2);
    idle;
    check({1'b0, ovr, rdy, pend}, 8'h20, "queue idle");
    $display("queue done");
    wrap_up;
  end
endmodule
